/* rtl/fpm_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
`define FPM_IDX_BURST 13
`define FPM_IDX_MODE 14
`define FPM_OFF_BURST (8'(`FPM_IDX_BURST * 4))
`define FPM_OFF_MODE (8'(`FPM_IDX_MODE * 4))
`define FPM_OFF_REG 8'h40
`define FPM_OFF_FB 8'h44
`define FPM_OFF_TIME 8'h48
`define FPM_OFF_STAT 8'h4c
`define FPM_BURST_LSB 0
`define FPM_MODE_SIMPLE_BIT 0
`define FPM_MODE_BURST_BIT 1
`define FPM_REG_FBDIS_BIT 0
`define FPM_REG_ASHUT_BIT 1
`define FPM_REG_ALLDIS_BIT 2
`define FPM_REG_ADIS_BIT 3
`define FPM_REG_DDIS_BIT 4
`define FPM_REG_BGDIS_BIT 5
`define FPM_REG_REPDIS_BIT 6
`define FPM_REG_ASET_BIT 7
`define FPM_REG_DSET_BIT 8
`define FPM_FB_HISEL_BIT 0
`define FPM_FB_COMB_BIT 1
`define FPM_FB_HISET_BIT 2
`define FPM_FB_LOSET_LSB 4
`define FPM_TIME_MINON_LSB 0
`define FPM_TIME_MINOFF_LSB 8
`define FPM_RST_LOSET 3'h0
`define FPM_RST_MINON 8'h10
`define FPM_RST_MINOFF 8'h10
`define FPM_SURGE_NS 20000
`define FPM_CLK_NS 10
`define FPM_SURGE_CYC (`FPM_SURGE_NS / `FPM_CLK_NS)
`endif

/* rtl/fpm_pkg.sv */
// types for the flyback power management control
`default_nettype none
package fpm_pkg;
  typedef enum logic [1:0] {FPM_HYST, FPM_SIMPLE, FPM_BURST} fpm_mode_type;
  typedef enum logic [1:0] {FPM_BOOT, FPM_WAIT_OUT, FPM_RUN} fpm_seq_type;
  typedef enum logic [1:0] {FPM_OFF, FPM_ON, FPM_OFF_WAIT} fpm_sw_type;
endpackage
`default_nettype wire

/* rtl/fpm_ctrl.sv */
// flyback power management control with axi4-lite register slave
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "fpm_consts.svh"
`default_nettype none
// How it works
// - drain not below reference during on-time stretches next off-time to 20 us.
// - reset leaves the controller in hysteretic mode; others need configuration.
// - simple-mode enable skips valley search.
// - burst mode ignores the reference for a 4-bit programmed count of cycles.
// - high-voltage regulators stay in standby while flyback feeds both rails.
// - flyback disable stops switching and turns high-voltage regulators on.
// - primary input above 6 V enables the start-up supply, starting the flyback.
// - flyback output reaching 3.3 V enables analog and digital 3 V regulators.
// - open-collector reset output low until power-on-reset rises, then released.
// - analog shutdown powers down analog except regulators, bandgap and flyback.
// - all-regulators disable turns off the analog and digital 3 V regulators, keeping the bandgap.
// - separate bits disable analog and digital 3 V regulators.
// - a dedicated bit turns the bandgap off.
// - replicator disable switches to bandgap current instead of replicated voltage.
// - each 3 V regulator set-point bit picks 3.0 V low, 3.2 V high.
// - high-rail select takes feedback from 10 V rail, else from 3 V rail.
// - combined enable regulates on both feedback inputs.
// - high-rail set-point bit selects regulation level when 10 V feedback used.
// - switch on when output below reference, off when current reaches peak.
// - 3-bit low-rail set-point code passes through, reset value 000.
// - minimum on-time blanks the current comparator after turn-on.
module fpm_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_above_6v,
  input wire logic flyback_out_good,
  input wire logic por_good,
  input wire logic low_rail_feedback_low,
  input wire logic high_rail_feedback_low,
  input wire logic peak_current_reached,
  input wire logic drain_below_ref,
  output logic switch_on,
  output logic startup_supply_enable,
  output logic hv_regs_standby,
  output logic analog_reg_enable,
  output logic digital_reg_enable,
  output logic bandgap_enable,
  output logic replicator_enable,
  output logic analog_shutdown,
  output logic analog_setpoint_high,
  output logic digital_setpoint_high,
  output logic high_rail_feedback_en,
  output logic low_rail_feedback_en,
  output logic high_rail_setpoint,
  output logic [2:0] low_rail_setpoint,
  output logic valley_search_enable,
  output logic reset_out_n_o,
  output logic reset_out_n_oe
);
  localparam logic [14:0] SURGE_CYC = 15'(`FPM_SURGE_CYC);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] burst_cnt_cfg;
    logic simple_en;
    logic burst_en;
    logic [8:0] reg_ctl;
    logic hi_sel;
    logic comb_en;
    logic hi_set;
    logic [2:0] lo_set;
    logic [7:0] min_on;
    logic [7:0] min_off;
    fpm_pkg::fpm_seq_type seq;
    fpm_pkg::fpm_sw_type sw;
    logic [14:0] tmr;
    logic surge;
    logic drain_seen;
    logic [3:0] burst_left;
    logic surge_seen;
  } fpm_state_type;

  fpm_state_type s_q;
  fpm_state_type s_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `FPM_OFF_BURST || a == `FPM_OFF_MODE || a == `FPM_OFF_REG ||
      a == `FPM_OFF_FB || a == `FPM_OFF_TIME || a == `FPM_OFF_STAT;
  endfunction

  logic fb_dis;
  logic all_dis;
  logic run_ok;
  logic fb_low;
  logic [31:0] rd_val;
  logic [31:0] wr_val;

  assign fb_dis = s_q.reg_ctl[`FPM_REG_FBDIS_BIT];
  assign all_dis = s_q.reg_ctl[`FPM_REG_ALLDIS_BIT];
  assign run_ok = s_q.seq == fpm_pkg::FPM_RUN;
  // combined uses either rail dipping; single uses the selected one
  assign fb_low = s_q.comb_en ? (low_rail_feedback_low | high_rail_feedback_low) :
    (s_q.hi_sel ? high_rail_feedback_low : low_rail_feedback_low);

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

  always_comb begin
    rd_val = 32'h0;
    case (s_axi_araddr)
      `FPM_OFF_BURST: rd_val = {28'h0, s_q.burst_cnt_cfg};
      `FPM_OFF_MODE: rd_val = {30'h0, s_q.burst_en, s_q.simple_en};
      `FPM_OFF_REG: rd_val = {23'h0, s_q.reg_ctl};
      `FPM_OFF_FB: rd_val = {25'h0, s_q.lo_set, 1'b0, s_q.hi_set, s_q.comb_en, s_q.hi_sel};
      `FPM_OFF_TIME: rd_val = {16'h0, s_q.min_off, s_q.min_on};
      `FPM_OFF_STAT: rd_val = {24'h0, s_q.surge_seen, s_q.surge, s_q.sw, s_q.seq, por_good, switch_on};
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    wr_val = 32'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awaddr) ? 2'h0 : 2'h2;
      case (s_q.awaddr)
        `FPM_OFF_BURST: begin
          wr_val = merge({28'h0, s_q.burst_cnt_cfg}, s_q.wdata, s_q.wstrb);
          s_d.burst_cnt_cfg = wr_val[`FPM_BURST_LSB +: 4];
        end
        `FPM_OFF_MODE: begin
          wr_val = merge({30'h0, s_q.burst_en, s_q.simple_en}, s_q.wdata, s_q.wstrb);
          s_d.simple_en = wr_val[`FPM_MODE_SIMPLE_BIT];
          s_d.burst_en = wr_val[`FPM_MODE_BURST_BIT];
        end
        `FPM_OFF_REG: begin
          wr_val = merge({23'h0, s_q.reg_ctl}, s_q.wdata, s_q.wstrb);
          s_d.reg_ctl = wr_val[8:0];
        end
        `FPM_OFF_FB: begin
          wr_val = merge({25'h0, s_q.lo_set, 1'b0, s_q.hi_set, s_q.comb_en, s_q.hi_sel}, s_q.wdata, s_q.wstrb);
          s_d.hi_sel = wr_val[`FPM_FB_HISEL_BIT];
          s_d.comb_en = wr_val[`FPM_FB_COMB_BIT];
          s_d.hi_set = wr_val[`FPM_FB_HISET_BIT];
          s_d.lo_set = wr_val[`FPM_FB_LOSET_LSB +: 3];
        end
        `FPM_OFF_TIME: begin
          wr_val = merge({16'h0, s_q.min_off, s_q.min_on}, s_q.wdata, s_q.wstrb);
          s_d.min_on = wr_val[`FPM_TIME_MINON_LSB +: 8];
          s_d.min_off = wr_val[`FPM_TIME_MINOFF_LSB +: 8];
        end
        default: begin
          wr_val = 32'h0;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      // sticky surge flag clears on status read; a new surge this cycle wins below
      if (s_axi_araddr == `FPM_OFF_STAT) begin
        s_d.surge_seen = 1'b0;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // power-up sequence
    case (s_q.seq)
      fpm_pkg::FPM_BOOT: begin
        if (primary_above_6v) begin
          s_d.seq = fpm_pkg::FPM_WAIT_OUT;
        end
      end
      fpm_pkg::FPM_WAIT_OUT: begin
        if (!primary_above_6v) begin
          s_d.seq = fpm_pkg::FPM_BOOT;
        end else if (flyback_out_good) begin
          s_d.seq = fpm_pkg::FPM_RUN;
        end
      end
      fpm_pkg::FPM_RUN: begin
        if (!primary_above_6v) begin
          s_d.seq = fpm_pkg::FPM_BOOT;
        end
      end
      default: s_d.seq = fpm_pkg::FPM_BOOT;
    endcase

    // switch control: timer counts controller clock cycles
    if (s_q.tmr != 15'h0) begin
      s_d.tmr = s_q.tmr - 15'h1;
    end
    case (s_q.sw)
      fpm_pkg::FPM_OFF: begin
        // burst keeps switching regardless of the reference while cycles remain
        if (s_q.seq != fpm_pkg::FPM_BOOT && !fb_dis &&
            (fb_low || (s_q.burst_en && s_q.burst_left != 4'h0))) begin
          s_d.sw = fpm_pkg::FPM_ON;
          s_d.tmr = {7'h0, s_q.min_on};
          s_d.drain_seen = 1'b0;
          if (s_q.burst_en) begin
            s_d.burst_left = fb_low ? s_q.burst_cnt_cfg : s_q.burst_left - 4'h1;
          end
        end
      end
      fpm_pkg::FPM_ON: begin
        if (drain_below_ref) begin
          s_d.drain_seen = 1'b1;
        end
        if (fb_dis) begin
          s_d.sw = fpm_pkg::FPM_OFF;
          s_d.tmr = 15'h0;
        end else if (s_q.tmr == 15'h0 && peak_current_reached) begin
          s_d.sw = fpm_pkg::FPM_OFF_WAIT;
          s_d.surge = !(s_q.drain_seen || drain_below_ref);
          // set only: a status read in this cycle must still clear the flag otherwise
          if (!(s_q.drain_seen || drain_below_ref)) begin
            s_d.surge_seen = 1'b1;
          end
          s_d.tmr = (s_q.drain_seen || drain_below_ref) ? {7'h0, s_q.min_off} : SURGE_CYC;
        end
      end
      fpm_pkg::FPM_OFF_WAIT: begin
        if (s_q.tmr == 15'h0) begin
          s_d.sw = fpm_pkg::FPM_OFF;
          s_d.surge = 1'b0;
        end
      end
      default: s_d.sw = fpm_pkg::FPM_OFF;
    endcase
    if (!s_q.burst_en) begin
      s_d.burst_left = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{default: '0, seq: fpm_pkg::FPM_BOOT, sw: fpm_pkg::FPM_OFF,
        lo_set: `FPM_RST_LOSET, min_on: `FPM_RST_MINON, min_off: `FPM_RST_MINOFF};
    end else begin
      s_q <= s_d;
    end
  end

  assign switch_on = s_q.sw == fpm_pkg::FPM_ON;
  assign startup_supply_enable = primary_above_6v;
  // hv regulators only stand by once the flyback carries both rails
  assign hv_regs_standby = run_ok && !fb_dis;
  assign analog_reg_enable = run_ok && !all_dis && !s_q.reg_ctl[`FPM_REG_ADIS_BIT];
  assign digital_reg_enable = run_ok && !all_dis && !s_q.reg_ctl[`FPM_REG_DDIS_BIT];
  assign bandgap_enable = !s_q.reg_ctl[`FPM_REG_BGDIS_BIT];
  assign replicator_enable = !s_q.reg_ctl[`FPM_REG_REPDIS_BIT];
  assign analog_shutdown = s_q.reg_ctl[`FPM_REG_ASHUT_BIT];
  assign analog_setpoint_high = s_q.reg_ctl[`FPM_REG_ASET_BIT];
  assign digital_setpoint_high = s_q.reg_ctl[`FPM_REG_DSET_BIT];
  assign high_rail_feedback_en = s_q.comb_en || s_q.hi_sel;
  assign low_rail_feedback_en = s_q.comb_en || !s_q.hi_sel;
  assign high_rail_setpoint = s_q.hi_set;
  assign low_rail_setpoint = s_q.lo_set;
  assign valley_search_enable = !s_q.simple_en;
  // open collector: only ever drives low
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe = !por_good;

  a_surge_off_time: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_q.sw == fpm_pkg::FPM_ON && s_d.sw == fpm_pkg::FPM_OFF_WAIT && s_d.surge) |=> s_q.tmr == SURGE_CYC)
    else $error("surge off time not loaded");
  a_blank_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (switch_on && s_q.tmr != 15'h0) |=> switch_on || fb_dis)
    else $error("switch left on-state during blanking");
  a_disable_stops: assert property (@(posedge mclk) disable iff (!rst_n)
    fb_dis |=> ##1 !switch_on)
    else $error("switching continued while disabled");
  a_hv_standby: assert property (@(posedge mclk) disable iff (!rst_n)
    hv_regs_standby |-> (s_q.seq == fpm_pkg::FPM_RUN && !fb_dis))
    else $error("hv standby without flyback");
  a_regs_all_off: assert property (@(posedge mclk) disable iff (!rst_n)
    all_dis |-> !analog_reg_enable && !digital_reg_enable)
    else $error("regulator on under global disable");
  a_reset_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    !por_good |-> reset_out_n_oe && !reset_out_n_o)
    else $error("reset pin released early");
  a_regs_need_run: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(analog_reg_enable) |-> $past(s_q.seq) != fpm_pkg::FPM_BOOT || $past(all_dis))
    else $error("regulators enabled before flyback good");
  a_turn_on_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(switch_on) |-> $past(fb_low) || $past(s_q.burst_left) != 4'h0)
    else $error("switch on without cause");

  // stretched off-time and its flags, then sequence, feedback, mode, burst and hv checks
  a_surge_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_q.sw == fpm_pkg::FPM_ON && s_d.sw == fpm_pkg::FPM_OFF_WAIT && s_d.surge) |=> s_q.surge_seen)
    else $error("surge flag not set");
  a_off_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_q.sw == fpm_pkg::FPM_OFF_WAIT) |=> !switch_on)
    else $error("switch on during off time");
  a_primary_loss: assert property (@(posedge mclk) disable iff (!rst_n)
    !primary_above_6v |=> s_q.seq == fpm_pkg::FPM_BOOT)
    else $error("sequence kept without primary");
  a_fb_single: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_q.comb_en |-> high_rail_feedback_en != low_rail_feedback_en)
    else $error("single feedback not exclusive");
  a_fb_combined: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.comb_en |-> high_rail_feedback_en && low_rail_feedback_en)
    else $error("combined feedback missing a rail");
  a_simple_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.simple_en |-> !valley_search_enable)
    else $error("valley search in simple mode");
  a_burst_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_q.sw == fpm_pkg::FPM_OFF && s_d.sw == fpm_pkg::FPM_ON && s_q.burst_en && fb_low) |=>
    s_q.burst_left == $past(s_q.burst_cnt_cfg))
    else $error("burst count not reloaded");
  a_hv_on_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    fb_dis |-> !hv_regs_standby)
    else $error("hv regulators idle while flyback disabled");
  c_surge: cover property (@(posedge mclk) disable iff (!rst_n) $rose(s_q.surge));
  c_burst: cover property (@(posedge mclk) disable iff (!rst_n) s_q.burst_en && switch_on && !fb_low);
  c_run: cover property (@(posedge mclk) disable iff (!rst_n) $rose(analog_reg_enable));
  c_surge_clear: cover property (@(posedge mclk) disable iff (!rst_n) $fell(s_q.surge_seen));
endmodule
`default_nettype wire

/* testbench/fpm_plant.sv */
// behavioural flyback plant: feedback comparators and drain current sense
`default_nettype none
module fpm_plant #(
  parameter int PK = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic switch_on,
  input wire logic need_lo,
  input wire logic need_hi,
  input wire logic surge,
  output logic low_rail_feedback_low,
  output logic high_rail_feedback_low,
  output logic peak_current_reached,
  output logic drain_below_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt;
  // primary current ramps only while the switch conducts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= switch_on ? on_cnt + 1 : 0;
    end
  end
  assign low_rail_feedback_low = need_lo;
  assign high_rail_feedback_low = need_hi;
  // early peak on purpose, so blanking must hold the switch on
  assign peak_current_reached = switch_on && on_cnt >= PK;
  // a surge keeps the drain above the reference for the whole on-time
  assign drain_below_ref = switch_on && !surge;
endmodule
`default_nettype wire

/* testbench/fpm_ctrl_test.sv */
// self-checking bench for the flyback power management control
`default_nettype none
module fpm_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic p6, fgood, por, need_lo, need_hi, surge, lo_low, hi_low, peak, dbr, sw, sw_p;
  logic sup, hvs, aen, den, bg, rep, ash, aset, dset, hfe, lfe, hset, vse, rst_o, rst_oe;
  logic [2:0] lset;
  int error_cnt, n_checks, cyc, run, on_len, off_len, n_rise, n;
  // address, data, expected outputs as packed by obs()
  logic [31:0] rows [23] = '{32'h400001f0, 32'h400002f9, 32'h40000431, 32'h40000871, 32'h400010b1,
    32'h400020d1, 32'h400040e1, 32'h400080f5, 32'h400100f3, 32'h400000f1, 32'h44000120, 32'h44000230,
    32'h44000418, 32'h44001011, 32'h44002012, 32'h44003013, 32'h44004014, 32'h44005015, 32'h44006016,
    32'h44007017, 32'h44000010, 32'h38000100, 32'h38000001};
  fpm_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_above_6v(p6),
    .flyback_out_good(fgood), .por_good(por), .low_rail_feedback_low(lo_low),
    .high_rail_feedback_low(hi_low), .peak_current_reached(peak), .drain_below_ref(dbr),
    .switch_on(sw), .startup_supply_enable(sup), .hv_regs_standby(hvs), .analog_reg_enable(aen),
    .digital_reg_enable(den), .bandgap_enable(bg), .replicator_enable(rep), .analog_shutdown(ash),
    .analog_setpoint_high(aset), .digital_setpoint_high(dset), .high_rail_feedback_en(hfe),
    .low_rail_feedback_en(lfe), .high_rail_setpoint(hset), .low_rail_setpoint(lset),
    .valley_search_enable(vse), .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe));
  fpm_plant #(.PK(1)) i_plant (.mclk(mclk), .rst_n(rst_n), .switch_on(sw), .need_lo(need_lo),
    .need_hi(need_hi), .surge(surge), .low_rail_feedback_low(lo_low), .high_rail_feedback_low(hi_low),
    .peak_current_reached(peak), .drain_below_ref(dbr));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // run lengths sampled mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    sw_p <= sw;
    if (sw === sw_p) begin
      run <= run + 1;
    end else begin
      if (sw_p) on_len <= run;
      else off_len <= run;
      run <= 1;
    end
    if (sw === 1'b1 && sw_p === 1'b0) n_rise <= n_rise + 1;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rng(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h to %h", $time, g, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    // ready is looked at mid-cycle and acted on at the taking edge
    while (!(da && dw)) begin
      @(negedge mclk);
      ta = !da && awready === 1'b1;
      tw = !dw && wready === 1'b1;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do @(negedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  function automatic logic [7:0] obs(input logic [7:0] a);
    if (a == 8'h40) return {aen, den, bg, rep, ash, aset, dset, hvs};
    if (a == 8'h44) return {2'h0, hfe, lfe, hset, lset};
    return {7'h0, vse};
  endfunction
  task automatic wait_rise;
    n = n_rise;
    do @(negedge mclk); while (n_rise == n);
  endtask
  task automatic pulse_run(input int e);
    int s;
    s = n_rise;
    @(posedge mclk);
    need_lo <= 1'b1;
    wait_rise();
    @(posedge mclk);
    need_lo <= 1'b0;
    repeat (150) @(negedge mclk);
    chk(n_rise - s, e);
  endtask
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, p6, fgood, por, need_lo, need_hi, surge} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {error_cnt, n_checks, n} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk({vse, lset, sw, rst_oe, rst_o, sup, aen}, 9'h108);
    rdr(8'h44);
    chk(rd, 32'h0);
    rdr(8'h48);
    chk(rd, 32'h1010);
    rdr(8'h00);
    chk(resp, 2'h2);
    chk(rd, 32'h0);
    wr(8'h00, 32'hffff);
    chk(resp, 2'h2);
    @(posedge mclk);
    p6 <= 1'b1;
    @(negedge mclk);
    chk(sup, 1'b1);
    @(posedge mclk);
    fgood <= 1'b1;
    repeat (10) @(negedge mclk);
    chk({aen, den, hvs, rst_oe}, 4'hf);
    @(posedge mclk);
    por <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(rst_oe, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][31:24], {16'h0, rows[i][23:8]});
      @(negedge mclk);
      chk({resp, obs(rows[i][31:24])}, {2'h0, rows[i][7:0]});
    end
    wr(8'h48, 32'h0604);
    @(posedge mclk);
    need_lo <= 1'b1;
    repeat (60) @(negedge mclk);
    rng(on_len, 4, 6);
    rng(off_len, 5, 9);
    @(posedge mclk);
    need_lo <= 1'b0;
    repeat (20) @(negedge mclk);
    n = n_rise;
    repeat (50) @(negedge mclk);
    chk(n_rise, n);
    wr(8'h44, 32'h2);
    @(posedge mclk);
    need_hi <= 1'b1;
    repeat (40) @(negedge mclk);
    rng(n_rise - n, 1, 9);
    @(posedge mclk);
    need_hi <= 1'b0;
    wr(8'h44, 32'h1);
    repeat (20) @(negedge mclk);
    n = n_rise;
    @(posedge mclk);
    need_lo <= 1'b1;
    repeat (40) @(negedge mclk);
    chk(n_rise, n);
    @(posedge mclk);
    need_lo <= 1'b0;
    wr(8'h44, 32'h0);
    // kept small so the reference is not ignored for long
    wr(8'h34, 32'h3);
    wr(8'h38, 32'h2);
    pulse_run(4);
    wr(8'h38, 32'h0);
    pulse_run(1);
    @(posedge mclk);
    surge <= 1'b1;
    need_lo <= 1'b1;
    wait_rise();
    do @(negedge mclk); while (sw !== 1'b0);
    @(posedge mclk);
    surge <= 1'b0;
    wait_rise();
    rng(off_len, 1999, 2004);
    wait_rise();
    rng(off_len, 5, 9);
    rdr(8'h4c);
    chk(rd[7:6], 2'h2);
    chk(rd[3:1], 3'h5);
    rdr(8'h4c);
    chk(rd[7], 1'b0);
    wr(8'h40, 32'h1);
    repeat (20) @(negedge mclk);
    n = n_rise;
    repeat (50) @(negedge mclk);
    chk(n_rise, n);
    chk(hvs, 1'b0);
    // simple mode set so the reset below has something to undo
    wr(8'h38, 32'h1);
    chk(vse, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(negedge mclk);
    chk({sw, vse}, 2'h1);
    @(posedge mclk);
    rst_n <= 1'b1;
    rdr(8'h40);
    chk(rd, 32'h0);
    rdr(8'h38);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
